// >>> serializer_general_config_map.svh
/*
  Register offsets, field positions, reset values and widths of the general
  configuration bank. Assumes inclusion by bare name from the package.
*/
`ifndef SERIALIZER_GENERAL_CONFIG_MAP_SVH
`define SERIALIZER_GENERAL_CONFIG_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RESERVED_TWO_ADDR          8'h02
`define GENERAL_CONFIGURATION_ADDR 8'h03
`define RESERVED_FOUR_ADDR         8'h04

// ---------------------------------------------------------------
// General configuration fields
// ---------------------------------------------------------------
`define GC_CRC_CHECK_EN_BIT        7
`define GC_PARITY_GEN_EN_BIT       6
`define GC_CRC_CLEAR_BIT           5
`define GC_AUTO_ACK_BIT            4
`define GC_PASS_ALL_BIT            3
`define GC_PASS_THRU_BIT           2
`define GC_PLL_OVERRIDE_BIT        1
`define GC_PIXEL_EDGE_BIT          0
`define GC_RESET_VALUE             8'hc5
`define RESERVED_READ_VALUE        8'h00

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define CRC_CNT_W                  8
`define I2C_ADDR_W                 7
`define I2C_ADDR_ZERO              7'h00

`endif

// >>> serializer_general_config_pkg.sv
/*
  Types shared by the general configuration bank and its I2C route logic.
  Assumes the map header is on the include path.
*/
package serializer_general_config_pkg;
  `include "serializer_general_config_map.svh"

  // Field order matches bit 7 down to bit 0
  typedef struct packed {
    logic crc_check_en;
    logic parity_gen_en;
    logic crc_clear;
    logic auto_ack_en;
    logic pass_all;
    logic pass_thru;
    logic pll_reference_override;
    logic pixel_edge_select;
  } gen_cfg_t;

  typedef struct packed {
    logic                   fwd;
    logic [`I2C_ADDR_W-1:0] fwd_addr;
    logic                   auto_ack;
    logic                   local_hit;
    logic                   drop;
  } route_t;
endpackage : serializer_general_config_pkg

// >>> i2c_route_if.sv
/*
  Carrier between the configuration bank and the I2C route decision.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface i2c_route_if;
  import serializer_general_config_pkg::*;
  logic                   req;
  logic                   write;
  logic [`I2C_ADDR_W-1:0] addr;
  logic                   locked;
  gen_cfg_t               cfg;
  logic [`I2C_ADDR_W-1:0] own_addr;
  logic [`I2C_ADDR_W-1:0] remote_deserializer_identifier;
  logic [`I2C_ADDR_W-1:0] des_alias;
  logic [`I2C_ADDR_W-1:0] tgt_id;
  logic [`I2C_ADDR_W-1:0] tgt_alias;
  route_t                 result;

  modport ctrl  (output req, write, addr, locked, cfg, own_addr, remote_deserializer_identifier, des_alias,
                 tgt_id, tgt_alias, input result);
  modport route (input req, write, addr, locked, cfg, own_addr, remote_deserializer_identifier, des_alias,
                 tgt_id, tgt_alias, output result);
endinterface : i2c_route_if

// >>> i2c_route_decide.sv
/*
  Registered forwarding decision for one local I2C address phase.
  Assumes request and settings come from logic on the same clock.
*/
`timescale 1ns/1ps
module i2c_route_decide (
  input  wire logic  clk_i,
  input  wire logic  reset_n_i,
  i2c_route_if.route rif
);
  import serializer_general_config_pkg::*;

  typedef struct packed {
    route_t r;
  } route_state_t;

  route_state_t st_ff;
  route_state_t nxt_st;

  logic own_hit;
  logic des_ok;
  logic tgt_ok;
  logic des_match;
  logic tgt_match;

  // ---------------------------------------------------------------
  // Decision
  // ---------------------------------------------------------------
  always_comb begin
    own_hit   = (rif.addr == rif.own_addr);
    des_ok    = (rif.remote_deserializer_identifier != `I2C_ADDR_ZERO); // RL14
    tgt_ok    = (rif.tgt_id != `I2C_ADDR_ZERO);
    des_match = des_ok && ((rif.addr == rif.remote_deserializer_identifier) ||
                (rif.cfg.pass_thru && rif.des_alias != `I2C_ADDR_ZERO &&
                 rif.addr == rif.des_alias)); // RL9 RL15
    tgt_match = tgt_ok && ((rif.addr == rif.tgt_id) ||
                (rif.cfg.pass_thru && rif.tgt_alias != `I2C_ADDR_ZERO &&
                 rif.addr == rif.tgt_alias)); // RL9
    nxt_st = '0;
    if (rif.req) begin
      if (own_hit) begin
        nxt_st.r.local_hit = 1'b1;
      end else if (rif.cfg.pass_all && des_ok) begin
        nxt_st.r.fwd      = 1'b1; // RL7
        nxt_st.r.fwd_addr = rif.remote_deserializer_identifier;
      end else if (!rif.cfg.pass_all && des_match) begin
        nxt_st.r.fwd      = 1'b1; // RL8
        nxt_st.r.fwd_addr = rif.remote_deserializer_identifier;
      end else if (!rif.cfg.pass_all && tgt_match) begin
        nxt_st.r.fwd      = 1'b1; // RL8
        nxt_st.r.fwd_addr = rif.tgt_id;
      end else begin
        nxt_st.r.drop = 1'b1;
      end
      // Auto ack only when link is locked; write still forwarded
      nxt_st.r.auto_ack = rif.cfg.auto_ack_en && rif.locked && rif.write &&
                          nxt_st.r.fwd && (rif.cfg.pass_all || des_match); // RL4 RL5 RL6
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rif.result = st_ff.r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_auto_ack_lock: assert property (rif.result.auto_ack |-> $past(rif.locked)) // RL4
    else $error("auto ack without lock");
  chk_auto_ack_fwd: assert property (rif.result.auto_ack |-> // RL6
      rif.result.fwd && rif.result.fwd_addr == $past(rif.remote_deserializer_identifier))
    else $error("auto ack not forwarded to remote id");
  chk_pass_all_remap: assert property ((rif.req && rif.cfg.pass_all && // RL7
      rif.addr != rif.own_addr && rif.remote_deserializer_identifier != `I2C_ADDR_ZERO) |=>
      rif.result.fwd && rif.result.fwd_addr == $past(rif.remote_deserializer_identifier))
    else $error("pass all not remapped");
  chk_zero_id_block: assert property ((rif.req && rif.remote_deserializer_identifier == `I2C_ADDR_ZERO && // RL14
      rif.tgt_id == `I2C_ADDR_ZERO) |=> !rif.result.fwd)
    else $error("forward with zero identifier");
  chk_own_local: assert property ((rif.req && rif.addr == rif.own_addr) |=> // RL8
      rif.result.local_hit && !rif.result.fwd)
    else $error("own address forwarded");
endmodule : i2c_route_decide

// >>> serializer_general_config.sv
/*
  General configuration register of the serializer with CRC error counter,
  PLL reference selection, pixel edge selection and I2C route decision.
  Assumes the local I2C target delivers decoded register accesses and address
  phases on clk_i; the mode pin is asynchronous.
*/
// How it works
// RL1 - Bit 7 enables back-channel CRC checker
// RL2 - Bit 6 enables forward parity generator
// RL3 - Bit 5 clears counters until written zero
// RL4 - Auto acknowledge acts only while locked
// RL5 - Auto acknowledge remote writes immediately
// RL6 - Auto-acked writes still forwarded, remapped
// RL7 - Pass-all forwards non-own addresses, remapped
// RL8 - Otherwise forward only deserializer/target matches
// RL9 - Bit 2 enables alias pass-through
// RL10 - Bit 1 selects PLL mode from register
// RL11 - Bit 1 zero: mode pin decides
// RL12 - Bit 0 selects rising or falling edge
// RL13 - Software avoids writing reserved locations
// RL14 - Zero identifier disables deserializer forwarding
// RL15 - Deserializer alias remapped to identifier
// RL16 - Counters held zero while clear set
`timescale 1ns/1ps
module serializer_general_config (
  input  wire logic                                 clk_i,
  input  wire logic                                 reset_n_i,
  // Register access
  input  wire logic [7:0]                           reg_addr_i,
  input  wire logic [7:0]                           reg_wdata_i,
  input  wire logic                                 reg_wr_i,
  input  wire logic                                 reg_rd_i,
  output logic      [7:0]                           reg_rdata_o,
  // Settings held elsewhere in the device
  input  wire logic [`I2C_ADDR_W-1:0]               own_addr_i,
  input  wire logic [`I2C_ADDR_W-1:0]               remote_deserializer_identifier_i,
  input  wire logic [`I2C_ADDR_W-1:0]               des_alias_i,
  input  wire logic [`I2C_ADDR_W-1:0]               tgt_id_i,
  input  wire logic [`I2C_ADDR_W-1:0]               tgt_alias_i,
  input  wire logic                                 pll_reg_mode_i,
  input  wire logic                                 mode_pin_i,
  // Link status and events
  input  wire logic                                 link_locked_i,
  input  wire logic                                 crc_error_i,
  // I2C address phase
  input  wire logic                                 i2c_req_i,
  input  wire logic                                 i2c_write_i,
  input  wire logic [`I2C_ADDR_W-1:0]               i2c_addr_i,
  // Controls
  output logic                                      crc_check_en_o,
  output logic                                      parity_gen_en_o,
  output logic                                      crc_clear_o,
  output logic                                      pll_ext_osc_mode_o,
  output logic                                      pixel_edge_select_o,
  output logic      [`CRC_CNT_W-1:0]                crc_err_count_o,
  // Route result
  output logic                                      fwd_o,
  output logic      [`I2C_ADDR_W-1:0]               fwd_addr_o,
  output logic                                      auto_ack_o,
  output logic                                      local_hit_o,
  output logic                                      drop_o
);
  import serializer_general_config_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    gen_cfg_t              cfg;
    logic [7:0]            rdata;
    logic                  mode_meta;
    logic                  mode_sync;
    logic                  pll_ext;
    logic [`CRC_CNT_W-1:0] crc_cnt;
  } cfg_state_t;

  localparam gen_cfg_t              CFG_RESET = gen_cfg_t'(`GC_RESET_VALUE);
  localparam logic [`CRC_CNT_W-1:0] CNT_MAX   = '1;

  cfg_state_t st_ff;
  cfg_state_t nxt_st;

  logic gc_wr;
  logic gc_rd;
  logic rsvd_rd;

  i2c_route_if rif ();

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st  = st_ff;
    gc_wr   = reg_wr_i && (reg_addr_i == `GENERAL_CONFIGURATION_ADDR);
    gc_rd   = reg_rd_i && (reg_addr_i == `GENERAL_CONFIGURATION_ADDR);
    rsvd_rd = reg_rd_i && ((reg_addr_i == `RESERVED_TWO_ADDR) ||
                           (reg_addr_i == `RESERVED_FOUR_ADDR));

    // Only the configuration word is writable; reserved writes dropped
    if (gc_wr) begin
      nxt_st.cfg = gen_cfg_t'(reg_wdata_i); // RL1 RL2 RL3 RL13
    end

    // Read data holds until the next read
    if (gc_rd) begin
      nxt_st.rdata = st_ff.cfg;
    end else if (rsvd_rd) begin
      nxt_st.rdata = `RESERVED_READ_VALUE; // RL13
    end else if (reg_rd_i) begin
      nxt_st.rdata = `RESERVED_READ_VALUE;
    end

    // Mode pin synchroniser
    nxt_st.mode_meta = mode_pin_i;
    nxt_st.mode_sync = st_ff.mode_meta;

    // PLL reference source
    if (st_ff.cfg.pll_reference_override) begin
      nxt_st.pll_ext = pll_reg_mode_i; // RL10
    end else begin
      nxt_st.pll_ext = st_ff.mode_sync; // RL11
    end

    // CRC error counter, saturating
    if (st_ff.cfg.crc_clear) begin
      nxt_st.crc_cnt = '0; // RL3 RL16
    end else if (crc_error_i && st_ff.cfg.crc_check_en && st_ff.crc_cnt != CNT_MAX) begin
      nxt_st.crc_cnt = st_ff.crc_cnt + 1'b1; // RL1
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff           <= '0;
      st_ff.cfg       <= CFG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Route decision
  // ---------------------------------------------------------------
  assign rif.req       = i2c_req_i;
  assign rif.write     = i2c_write_i;
  assign rif.addr      = i2c_addr_i;
  assign rif.locked    = link_locked_i;
  assign rif.cfg       = st_ff.cfg;
  assign rif.own_addr  = own_addr_i;
  assign rif.remote_deserializer_identifier    = remote_deserializer_identifier_i;
  assign rif.des_alias = des_alias_i;
  assign rif.tgt_id    = tgt_id_i;
  assign rif.tgt_alias = tgt_alias_i;

  i2c_route_decide u_route (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .rif       (rif.route)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o         = st_ff.rdata;
  assign crc_check_en_o      = st_ff.cfg.crc_check_en; // RL1
  assign parity_gen_en_o     = st_ff.cfg.parity_gen_en; // RL2
  assign crc_clear_o         = st_ff.cfg.crc_clear;
  assign pll_ext_osc_mode_o  = st_ff.pll_ext;
  assign pixel_edge_select_o = st_ff.cfg.pixel_edge_select; // RL12
  assign crc_err_count_o     = st_ff.crc_cnt;
  assign fwd_o               = rif.result.fwd;
  assign fwd_addr_o          = rif.result.fwd_addr;
  assign auto_ack_o          = rif.result.auto_ack; // RL5
  assign local_hit_o         = rif.result.local_hit;
  assign drop_o              = rif.result.drop;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence gc_write_s;
    reg_wr_i && reg_addr_i == `GENERAL_CONFIGURATION_ADDR;
  endsequence

  sequence no_gc_write_s;
    !(reg_wr_i && reg_addr_i == `GENERAL_CONFIGURATION_ADDR);
  endsequence

  chk_crc_en_write: assert property (gc_write_s |=>
      crc_check_en_o == $past(reg_wdata_i[`GC_CRC_CHECK_EN_BIT])) // RL1
    else $error("crc checker enable not taken");
  chk_parity_write: assert property (gc_write_s |=>
      parity_gen_en_o == $past(reg_wdata_i[`GC_PARITY_GEN_EN_BIT])) // RL2
    else $error("parity enable not taken");
  chk_clear_sticky: assert property ((crc_clear_o ##0 no_gc_write_s) |=> crc_clear_o) // RL3
    else $error("clear bit dropped without write");
  chk_clear_holds_zero: assert property (crc_clear_o |=> crc_err_count_o == '0) // RL16
    else $error("counter not held at zero");
  chk_count_step: assert property ((crc_error_i && crc_check_en_o && !crc_clear_o && // RL1
      crc_err_count_o != CNT_MAX) |=> crc_err_count_o == $past(crc_err_count_o) + 1'b1)
    else $error("crc error not counted");
  chk_no_count_off: assert property ((!crc_check_en_o && !crc_clear_o) |=> // RL1
      crc_err_count_o == $past(crc_err_count_o))
    else $error("counter moved while checker off");
  chk_pll_override: assert property ((st_ff.cfg.pll_reference_override ##0 // RL10
      no_gc_write_s) |=> pll_ext_osc_mode_o == $past(pll_reg_mode_i))
    else $error("pll mode not from register");
  chk_pll_pin: assert property (!st_ff.cfg.pll_reference_override |=> // RL11
      pll_ext_osc_mode_o == $past(st_ff.mode_sync))
    else $error("pll mode not from pin");
  chk_pin_latency: assert property ((!st_ff.cfg.pll_reference_override [*4]) |->
      pll_ext_osc_mode_o == $past(mode_pin_i, 3)) // RL11
    else $error("pin to pll mode latency wrong");
  chk_edge_write: assert property (gc_write_s |=>
      pixel_edge_select_o == $past(reg_wdata_i[`GC_PIXEL_EDGE_BIT])) // RL12
    else $error("pixel edge select not taken");
  chk_rsvd_read: assert property ((reg_rd_i && reg_addr_i == `RESERVED_TWO_ADDR) |=>
      reg_rdata_o == `RESERVED_READ_VALUE) // RL13
    else $error("reserved read not zero");
  chk_gc_readback: assert property ((reg_rd_i && reg_addr_i == `GENERAL_CONFIGURATION_ADDR)
      |=> reg_rdata_o == $past(st_ff.cfg))
    else $error("config readback wrong");
  chk_auto_ack_only_write: assert property (auto_ack_o |-> $past(i2c_write_i) && fwd_o) // RL5
    else $error("auto ack on read");

  chk_clear_write: assert property (gc_write_s |=> // RL3
      crc_clear_o == $past(reg_wdata_i[`GC_CRC_CLEAR_BIT]))
    else $error("clear bit not taken");

  chk_thru_write: assert property (gc_write_s |=> // RL9
      st_ff.cfg.pass_thru == $past(reg_wdata_i[`GC_PASS_THRU_BIT]))
    else $error("pass-through bit not taken");

  chk_cfg_hold: assert property (no_gc_write_s |=> // RL13
      $stable(st_ff.cfg))
    else $error("config changed without write");

  chk_rsvd4_read: assert property ((reg_rd_i && // RL13
      reg_addr_i == `RESERVED_FOUR_ADDR) |=>
      reg_rdata_o == `RESERVED_READ_VALUE)
    else $error("reserved four read not zero");

  chk_count_sat: assert property ((crc_err_count_o == CNT_MAX && // RL1
      !crc_clear_o) |=> crc_err_count_o == CNT_MAX)
    else $error("counter wrapped");

  // ---------------------------------------------------------------
  // Route checks
  // ---------------------------------------------------------------
  sequence route_req_s;
    i2c_req_i && i2c_addr_i != own_addr_i;
  endsequence

  chk_route_onehot: assert property (i2c_req_i |=> // RL8
      $onehot({fwd_o, local_hit_o, drop_o}))
    else $error("route result not one-hot");

  chk_route_idle: assert property (!i2c_req_i |=> // RL8
      !(fwd_o || local_hit_o || drop_o || auto_ack_o))
    else $error("route result without request");

  chk_fwd_addr_idle: assert property (!fwd_o |-> // RL6
      fwd_addr_o == `I2C_ADDR_ZERO)
    else $error("forward address without forward");

  chk_ack_needs_lock: assert property ((i2c_req_i && !link_locked_i) |=> // RL4
      !auto_ack_o)
    else $error("auto ack while unlocked");

  chk_ack_bit_off: assert property ((i2c_req_i && !st_ff.cfg.auto_ack_en) |=> // RL5
      !auto_ack_o)
    else $error("auto ack while disabled");

  chk_ack_pass_all: assert property ((route_req_s ##0 (i2c_write_i && // RL5
      link_locked_i && st_ff.cfg.auto_ack_en && st_ff.cfg.pass_all &&
      remote_deserializer_identifier_i != `I2C_ADDR_ZERO)) |=>
      auto_ack_o && fwd_o)
    else $error("pass all write not auto acked");

  chk_ack_des_write: assert property ((route_req_s ##0 (i2c_write_i && // RL5
      link_locked_i && st_ff.cfg.auto_ack_en &&
      remote_deserializer_identifier_i != `I2C_ADDR_ZERO &&
      i2c_addr_i == remote_deserializer_identifier_i)) |=>
      auto_ack_o && fwd_o)
    else $error("deserializer write not auto acked");

  chk_alias_remap: assert property ((route_req_s ##0 (st_ff.cfg.pass_thru && // RL15
      des_alias_i != `I2C_ADDR_ZERO && i2c_addr_i == des_alias_i &&
      remote_deserializer_identifier_i != `I2C_ADDR_ZERO)) |=>
      fwd_o && fwd_addr_o == $past(remote_deserializer_identifier_i))
    else $error("alias not remapped to identifier");

  chk_alias_off: assert property ((route_req_s ##0 (!st_ff.cfg.pass_all && // RL9
      !st_ff.cfg.pass_thru &&
      i2c_addr_i != remote_deserializer_identifier_i &&
      i2c_addr_i != tgt_id_i)) |=> drop_o)
    else $error("access passed with pass-through off");

  chk_tgt_remap: assert property ((route_req_s ##0 (!st_ff.cfg.pass_all && // RL8
      tgt_id_i != `I2C_ADDR_ZERO && i2c_addr_i == tgt_id_i &&
      i2c_addr_i != remote_deserializer_identifier_i &&
      i2c_addr_i != des_alias_i)) |=>
      fwd_o && fwd_addr_o == $past(tgt_id_i))
    else $error("target access not forwarded");

  chk_zero_id_all: assert property ((route_req_s ##0 (st_ff.cfg.pass_all && // RL14
      remote_deserializer_identifier_i == `I2C_ADDR_ZERO)) |=>
      drop_o && !fwd_o)
    else $error("pass all forwarded with zero identifier");
endmodule : serializer_general_config

// >>> remote_link_model.sv
/*
  Far-side model: remote deserializer link state and back-channel CRC errors.
  Assumes the bench requests lock and error events on the same clock.
*/
`timescale 1ns/1ps
module remote_link_model #(
  parameter int LOCK_DELAY = 4
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic want_lock_i,
  input  wire logic err_req_i,
  output logic      locked_o,
  output logic      crc_error_o
);
  // ---------------------------------------------------------------
  // Lock follows request after a delay
  // ---------------------------------------------------------------
  int wait_ff;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_ff     <= 0;
      locked_o    <= 1'b0;
      crc_error_o <= 1'b0;
    end else begin
      crc_error_o <= err_req_i;
      if (want_lock_i == locked_o) begin
        wait_ff <= 0;
      end else if (wait_ff == LOCK_DELAY) begin
        wait_ff  <= 0;
        locked_o <= want_lock_i;
      end else begin
        wait_ff <= wait_ff + 1;
      end
    end
  end
endmodule : remote_link_model

// >>> testbench.sv
/*
  Self-checking bench for the general configuration bank and route logic.
  Assumes the design package and map header are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import serializer_general_config_pkg::*;
  typedef struct packed {
    gen_cfg_t    cfg;
    logic        lock;
    logic        wr;
    logic [6:0]  addr;
    logic [10:0] exp;
  } row_t;

  logic        clk_i, reset_n_i, reg_wr, reg_rd, pll_reg_mode, mode_pin, want_lock, err_req;
  logic        req, wr, locked, crc_error, crc_en, par_en, clr, pll_mode, pix, fwd, ack, hit;
  logic        drop;
  logic [7:0]  reg_addr, reg_wdata, rdata, count;
  logic [6:0]  own_addr, remote_deserializer_identifier, des_alias, tgt_id, tgt_alias, addr, fwd_addr;
  int          bad_count, total_checks, cycles;
  row_t        rows [14];

  serializer_general_config serializer_general_config_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .own_addr_i(own_addr),
    .remote_deserializer_identifier_i(remote_deserializer_identifier), .des_alias_i(des_alias), .tgt_id_i(tgt_id),
    .tgt_alias_i(tgt_alias), .pll_reg_mode_i(pll_reg_mode), .mode_pin_i(mode_pin),
    .link_locked_i(locked), .crc_error_i(crc_error), .i2c_req_i(req), .i2c_write_i(wr),
    .i2c_addr_i(addr), .crc_check_en_o(crc_en), .parity_gen_en_o(par_en), .crc_clear_o(clr),
    .pll_ext_osc_mode_o(pll_mode), .pixel_edge_select_o(pix), .crc_err_count_o(count),
    .fwd_o(fwd), .fwd_addr_o(fwd_addr), .auto_ack_o(ack), .local_hit_o(hit), .drop_o(drop));

  remote_link_model remote_link_model_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .want_lock_i(want_lock), .err_req_i(err_req),
    .locked_o(locked), .crc_error_o(crc_error));

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict;
    end
  end

  task check(input string name, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task clocks(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : clocks

  task reg_write(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h02 || a == 8'h04) return;
    @(posedge clk_i); #1;
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    clocks(1);
    reg_wr = 1'b0;
  endtask : reg_write

  task reg_read(input logic [7:0] a);
    @(posedge clk_i); #1;
    reg_rd = 1'b1; reg_addr = a;
    clocks(1);
    reg_rd = 1'b0;
  endtask : reg_read

  task route(input logic w, input logic [6:0] a);
    @(posedge clk_i); #1;
    req = 1'b1; wr = w; addr = a;
    clocks(1);
    req = 1'b0;
  endtask : route

  task pulse_err;
    @(posedge clk_i); #1;
    err_req = 1'b1;
    clocks(1);
    err_req = 1'b0;
    clocks(2);
  endtask : pulse_err

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_n_i, reg_wr, reg_rd, pll_reg_mode, mode_pin, want_lock, err_req, req, wr} = '0;
    {reg_addr, reg_wdata, addr} = '0;
    own_addr = 7'h1a; remote_deserializer_identifier = 7'h30; des_alias = 7'h31; tgt_id = 7'h40; tgt_alias = 7'h41;
    rows = '{'{8'hc5, 1'b0, 1'b1, 7'h1a, 11'h002}, '{8'h01, 1'b0, 1'b1, 7'h30, 11'h580},
             '{8'hc5, 1'b0, 1'b1, 7'h31, 11'h580}, '{8'h40, 1'b0, 1'b1, 7'h31, 11'h001},
             '{8'h85, 1'b0, 1'b1, 7'h41, 11'h600}, '{8'hc4, 1'b0, 1'b1, 7'h55, 11'h001},
             '{8'hcd, 1'b0, 1'b1, 7'h55, 11'h580}, '{8'hcd, 1'b0, 1'b1, 7'h1a, 11'h002},
             '{8'hd5, 1'b1, 1'b1, 7'h31, 11'h584}, '{8'hd5, 1'b0, 1'b1, 7'h31, 11'h580},
             '{8'hd5, 1'b1, 1'b0, 7'h31, 11'h580}, '{8'hd5, 1'b1, 1'b1, 7'h41, 11'h600},
             '{8'hdd, 1'b1, 1'b1, 7'h55, 11'h584}, '{8'h9d, 1'b1, 1'b1, 7'h41, 11'h584}};
    clocks(10);
    reset_n_i = 1'b1;
    clocks(1);
    reg_read(8'h03);
    check("reset config", 11'h0c5, {3'b0, rdata});
    check("reset outputs", 11'h019, {6'b0, crc_en, par_en, clr, pll_mode, pix});
    $display("test reset done");

    for (int i = 0; i < 14; i++) begin
      reg_write(8'h03, rows[i].cfg);
      want_lock = rows[i].lock;
      for (int k = 0; k < 20 && locked !== rows[i].lock; k++) clocks(1);
      route(rows[i].wr, rows[i].addr);
      check("route", rows[i].exp, {fwd, fwd_addr, ack, hit, drop});
      check("cfg outputs", {8'b0, rows[i].cfg[7:6], rows[i].cfg[0]}, {8'b0, crc_en, par_en, pix});
      reg_read(8'h03);
      check("readback", {3'b0, rows[i].cfg}, {3'b0, rdata});
    end
    $display("test route table done");

    reg_write(8'h03, 8'hc5);
    reg_write(8'h05, 8'h00);
    reg_read(8'h03);
    check("unmapped write", 11'h0c5, {3'b0, rdata});
    reg_read(8'h02);
    check("reserved 02", 11'h000, {3'b0, rdata});
    reg_read(8'h04);
    check("reserved 04", 11'h000, {3'b0, rdata});
    $display("test reserved done");

    remote_deserializer_identifier = 7'h00;
    route(1'b1, 7'h31);
    check("zero id alias", 11'h001, {fwd, fwd_addr, ack, hit, drop});
    reg_write(8'h03, 8'hcd);
    route(1'b1, 7'h55);
    check("zero id pass all", 11'h001, {fwd, fwd_addr, ack, hit, drop});
    remote_deserializer_identifier = 7'h30;
    $display("test zero identifier done");

    mode_pin = 1'b1;
    clocks(4);
    check("pin mode", 11'h001, {10'b0, pll_mode});
    reg_write(8'h03, 8'hc7);
    clocks(1);
    check("override low", 11'h000, {10'b0, pll_mode});
    pll_reg_mode = 1'b1;
    clocks(2);
    check("override high", 11'h001, {10'b0, pll_mode});
    reg_write(8'h03, 8'hc5);
    mode_pin = 1'b0;
    clocks(4);
    check("pin back", 11'h000, {10'b0, pll_mode});
    $display("test pll mode done");

    repeat (3) pulse_err;
    check("count three", 11'h003, {3'b0, count});
    reg_write(8'h03, 8'he5);
    clocks(1);
    check("clear held", 11'h100, {2'b0, clr, count});
    pulse_err;
    check("clear blocks", 11'h100, {2'b0, clr, count});
    reg_write(8'h03, 8'hc5);
    pulse_err;
    check("count resumes", 11'h001, {3'b0, count});
    reg_write(8'h03, 8'h45);
    pulse_err;
    check("checker off", 11'h001, {3'b0, count});
    $display("test crc counter done");

    reg_write(8'h03, 8'h00);
    reset_n_i = 1'b0;
    clocks(2);
    reset_n_i = 1'b1;
    reg_read(8'h03);
    check("second reset", 11'h0c5, {3'b0, rdata});
    check("second reset count", 11'h000, {3'b0, count});
    $display("test second reset done");
    give_verdict;
  end
endmodule : testbench
